// ===== common/tcf_defines.svh
// constants for the timer 1 block and its control flags register
`ifndef TCF_DEFINES_SVH
`define TCF_DEFINES_SVH
`define TCF_ADDR_W 8
`define TCF_ADDR_CTRL 8'h88
`define TCF_ADDR_MODE 8'h89
`define TCF_ADDR_LOW 8'h8B
`define TCF_ADDR_HIGH 8'h8D
`define TCF_CTRL_RESET 8'h00
`define TCF_MODE_RESET 8'h00
`define TCF_CNT_RESET 8'h00
`define TCF_BIT_T1_OVF 7
`define TCF_BIT_T1_RUN 6
`define TCF_BIT_T0_OVF 5
`define TCF_BIT_T0_RUN 4
`define TCF_BIT_X1_FLAG 3
`define TCF_BIT_X1_TYPE 2
`define TCF_BIT_X0_FLAG 1
`define TCF_BIT_X0_TYPE 0
`define TCF_BIT_GATE 7
`define TCF_BIT_SRC 6
`define TCF_BIT_MODE_HI 5
`define TCF_BIT_MODE_LO 4
`define TCF_OSC_PER_TICK 12
`define TCF_TICK_W 4
`define TCF_PRESCALE_MAX 5'h1F
`define TCF_BYTE_MAX 8'hFF
`endif

// ===== common/tcf_pkg.sv
// types for the timer 1 block
package tcf_pkg;
  typedef enum logic [1:0] {
    TCF_MODE_13BIT,
    TCF_MODE_16BIT,
    TCF_MODE_RELOAD,
    TCF_MODE_HALT
  } tcf_mode_e;
  typedef logic [7:0] tcf_byte_t;
endpackage : tcf_pkg

// ===== rtl/tcf_timer1.sv
// timer 1 with the shared timer control flags register
//
// Operation
// - timer 1 driven by mode bits 7..4 and control bits 7,6.
// - modes 0, 1, 2 behave like timer 0 with own registers.
// - gate select clear: count only while run bit set.
// - rollover from all ones sets timer 1 overflow flag.
// - mode 0 uses low five bits as modulo-32 prescaler into high byte.
// - mode 0 ignores upper three bits of low count.
// - mode 0 prescaler wrap bumps high byte; high wrap sets overflow.
// - mode 1 cascades high and low into one 16-bit counter.
// - mode 2 low byte counts, overflow sets flag and reloads from high.
// - mode 2 reload leaves the high byte untouched.
// - mode 3 halts timer 1 and holds its count.
// - timer 0 in mode 3 borrows timer 1 overflow flag and run bit.
// - overflow flags set on overflow, cleared on interrupt vectoring.
// - run bits turn timers on when written one, off when zero.
// - external flags set on pin event; edge mode clears on service.
// - type bits: zero low level, one falling edge.
// - control register reads zero after reset.
// - timer operation counts once per twelve oscillator periods.
// - counter operation counts on pin sample high then low.
// - mode bits: 00 13-bit, 01 16-bit, 10 reload, 11 halted.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "tcf_defines.svh"

module tcf_timer1
  import tcf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [`TCF_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic timer1_count_pin,
  input wire logic ext_irq1_pin,
  input wire logic ext_irq0_pin,
  // timer 0 side: its mode 3 upper counter and its own overflow event
  input wire logic timer0_in_mode3,
  input wire logic timer0_high_ovf,
  input wire logic timer0_ovf,
  // interrupt controller acknowledges
  input wire logic ack_timer1,
  input wire logic ack_timer0,
  input wire logic ack_ext1,
  input wire logic ack_ext0,
  // control outputs
  output logic timer1_overflow_flag,
  output logic timer0_overflow_flag,
  output logic timer0_run_bit,
  output logic timer1_run_bit,
  output logic ext_irq1_flag,
  output logic ext_irq0_flag,
  output logic ext_irq1_type,
  output logic ext_irq0_type,
  output logic timer1_ovf_pulse
);

  tcf_byte_t timer_control_flags;
  tcf_byte_t timer_mode_reg;
  tcf_byte_t timer1_low_count;
  tcf_byte_t timer1_high_count;
  logic [`TCF_TICK_W-1:0] tick_cnt;
  logic pin_q;
  logic x1_q;
  logic x0_q;

  // wrap test shared by the low and high byte paths; the mode 0 prescaler compares its own five bits
  function automatic logic is_max(input tcf_byte_t v);
    is_max = (v == `TCF_BYTE_MAX);
  endfunction : is_max

  // register decode
  wire wr_ctrl = reg_wr && (reg_addr == `TCF_ADDR_CTRL);
  wire wr_mode = reg_wr && (reg_addr == `TCF_ADDR_MODE);
  wire wr_low = reg_wr && (reg_addr == `TCF_ADDR_LOW);
  wire wr_high = reg_wr && (reg_addr == `TCF_ADDR_HIGH);

  // mode fields of the upper nibble
  wire timer1_gate_select = timer_mode_reg[`TCF_BIT_GATE];
  wire timer1_source_select = timer_mode_reg[`TCF_BIT_SRC];
  wire timer1_mode_hi = timer_mode_reg[`TCF_BIT_MODE_HI];
  wire timer1_mode_lo = timer_mode_reg[`TCF_BIT_MODE_LO];
  wire [1:0] mode_code = {timer1_mode_hi, timer1_mode_lo};
  wire tcf_mode_e mode = tcf_mode_e'(mode_code);

  // peripheral tick: one mclk pulse per twelve periods
  wire tick = (tick_cnt == `TCF_TICK_W'(`TCF_OSC_PER_TICK - 1));

  // count pin falling detection, sampled once per peripheral cycle
  wire pin_fall = pin_q && !timer1_count_pin;
  wire src_event = timer1_source_select ? (tick && pin_fall) : tick;

  // run gating; with gate set the irq1 pin must be high too
  // timer 0 in mode 3 owns the run bit, so timer 1 then stops only by halt mode or by the gate with the irq1 pin low
  wire run_bit_ok = timer1_run_bit || timer0_in_mode3;
  wire run_ok = run_bit_ok && (!timer1_gate_select || ext_irq1_pin);
  wire inc = src_event && run_ok && (mode != TCF_MODE_HALT);

  // per-mode carry chain
  wire pre_wrap = (timer1_low_count[4:0] == `TCF_PRESCALE_MAX);
  wire low_wrap = is_max(timer1_low_count);
  wire high_wrap = is_max(timer1_high_count);
  wire ovf13 = (mode == TCF_MODE_13BIT) && pre_wrap && high_wrap;
  wire ovf16 = (mode == TCF_MODE_16BIT) && low_wrap && high_wrap;
  wire ovf8 = (mode == TCF_MODE_RELOAD) && low_wrap;
  wire t1_ovf = inc && (ovf13 || ovf16 || ovf8);

  // next low count; upper three bits untouched in mode 0
  logic [7:0] next_low;
  logic [7:0] next_high;
  always_comb begin
    next_low = timer1_low_count;
    next_high = timer1_high_count;
    if (inc) begin
      unique case (mode)
        TCF_MODE_13BIT: begin
          next_low = {timer1_low_count[7:5], 5'(timer1_low_count[4:0] + 5'h1)};
          if (pre_wrap) next_high = 8'(timer1_high_count + 8'h1);
        end
        TCF_MODE_16BIT: begin
          next_low = 8'(timer1_low_count + 8'h1);
          if (low_wrap) next_high = 8'(timer1_high_count + 8'h1);
        end
        TCF_MODE_RELOAD: begin
          next_low = low_wrap ? timer1_high_count : 8'(timer1_low_count + 8'h1);
        end
        TCF_MODE_HALT: begin
          next_low = timer1_low_count;
        end
      endcase
    end
    // software writes take priority over counting
    if (wr_low) next_low = reg_wdata;
    if (wr_high) next_high = reg_wdata;
  end

  // flag sources; timer 0 mode 3 borrows the timer 1 overflow flag
  wire t1_flag_src = timer0_in_mode3 ? timer0_high_ovf : t1_ovf;
  wire x1_fall = x1_q && !ext_irq1_pin;
  wire x0_fall = x0_q && !ext_irq0_pin;
  wire x1_set = ext_irq1_type ? x1_fall : !ext_irq1_pin;
  wire x0_set = ext_irq0_type ? x0_fall : !ext_irq0_pin;

  // next control value: set beats any clear in the same cycle
  tcf_byte_t next_ctrl;
  always_comb begin
    next_ctrl = timer_control_flags;
    if (wr_ctrl) next_ctrl = reg_wdata;
    if (ack_timer1) next_ctrl[`TCF_BIT_T1_OVF] = 1'b0;
    if (ack_timer0) next_ctrl[`TCF_BIT_T0_OVF] = 1'b0;
    if (ack_ext1 && ext_irq1_type) next_ctrl[`TCF_BIT_X1_FLAG] = 1'b0;
    if (ack_ext0 && ext_irq0_type) next_ctrl[`TCF_BIT_X0_FLAG] = 1'b0;
    // level mode flag follows the pin level
    if (!ext_irq1_type && !x1_set) next_ctrl[`TCF_BIT_X1_FLAG] = 1'b0;
    if (!ext_irq0_type && !x0_set) next_ctrl[`TCF_BIT_X0_FLAG] = 1'b0;
    if (t1_flag_src) next_ctrl[`TCF_BIT_T1_OVF] = 1'b1;
    if (timer0_ovf) next_ctrl[`TCF_BIT_T0_OVF] = 1'b1;
    if (x1_set) next_ctrl[`TCF_BIT_X1_FLAG] = 1'b1;
    if (x0_set) next_ctrl[`TCF_BIT_X0_FLAG] = 1'b1;
  end

  // control register fields
  assign timer1_overflow_flag = timer_control_flags[`TCF_BIT_T1_OVF];
  assign timer1_run_bit = timer_control_flags[`TCF_BIT_T1_RUN];
  assign timer0_overflow_flag = timer_control_flags[`TCF_BIT_T0_OVF];
  assign timer0_run_bit = timer_control_flags[`TCF_BIT_T0_RUN];
  assign ext_irq1_flag = timer_control_flags[`TCF_BIT_X1_FLAG];
  assign ext_irq1_type = timer_control_flags[`TCF_BIT_X1_TYPE];
  assign ext_irq0_flag = timer_control_flags[`TCF_BIT_X0_FLAG];
  assign ext_irq0_type = timer_control_flags[`TCF_BIT_X0_TYPE];

  // read mux, unmapped reads give zero
  wire [7:0] rd_mux =
    (reg_addr == `TCF_ADDR_CTRL) ? timer_control_flags :
    (reg_addr == `TCF_ADDR_MODE) ? timer_mode_reg :
    (reg_addr == `TCF_ADDR_LOW) ? timer1_low_count :
    (reg_addr == `TCF_ADDR_HIGH) ? timer1_high_count : 8'h00;

  // prescale divider
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tick_cnt <= '0;
    else if (tick) tick_cnt <= '0;
    else tick_cnt <= `TCF_TICK_W'(tick_cnt + `TCF_TICK_W'(1));
  end

  // pin samplers; the count pin is sampled only on a tick, so a level
  // shorter than a peripheral cycle can be missed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      x1_q <= 1'b1;
      x0_q <= 1'b1;
    end else begin
      if (tick) pin_q <= timer1_count_pin;
      x1_q <= ext_irq1_pin;
      x0_q <= ext_irq0_pin;
    end
  end

  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_flags <= `TCF_CTRL_RESET;
      timer_mode_reg <= `TCF_MODE_RESET;
      timer1_low_count <= `TCF_CNT_RESET;
      timer1_high_count <= `TCF_CNT_RESET;
    end else begin
      timer_control_flags <= next_ctrl;
      if (wr_mode) timer_mode_reg <= reg_wdata;
      timer1_low_count <= next_low;
      timer1_high_count <= next_high;
    end
  end

  // read data and overflow pulse
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      timer1_ovf_pulse <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      timer1_ovf_pulse <= t1_ovf;
    end
  end

  // assertions
  property p_ovf_sets_flag;
    @(posedge mclk) disable iff (!rst_n) (t1_ovf && !timer0_in_mode3) |=> timer1_overflow_flag;
  endproperty
  a_ovf_sets_flag: assert property (p_ovf_sets_flag) else $error("overflow did not set flag");

  property p_reload;
    @(posedge mclk) disable iff (!rst_n)
      (inc && mode == TCF_MODE_RELOAD && low_wrap && !wr_low && !wr_high)
      |=> (timer1_low_count == $past(timer1_high_count)) && $stable(timer1_high_count);
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong");

  property p_halt_holds;
    @(posedge mclk) disable iff (!rst_n)
      (mode == TCF_MODE_HALT && !wr_low && !wr_high) |=> $stable(timer1_low_count) && $stable(timer1_high_count);
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("halt mode changed count");

  property p_no_run_no_count;
    @(posedge mclk) disable iff (!rst_n)
      (!timer1_run_bit && !timer0_in_mode3 && !wr_low && !wr_high) |=> $stable(timer1_low_count);
  endproperty
  a_no_run_no_count: assert property (p_no_run_no_count) else $error("counted while stopped");

  property p_gate_blocks;
    @(posedge mclk) disable iff (!rst_n)
      (timer1_gate_select && !ext_irq1_pin && !wr_low && !wr_high) |=> $stable(timer1_low_count);
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("gate did not block");

  property p_tick_spacing;
    @(posedge mclk) disable iff (!rst_n) tick |=> !tick [*8] ##1 !tick [*3] ##1 tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing not twelve");

  property p_mode0_upper;
    @(posedge mclk) disable iff (!rst_n)
      (mode == TCF_MODE_13BIT && !wr_low) |=> timer1_low_count[7:5] == $past(timer1_low_count[7:5]);
  endproperty
  a_mode0_upper: assert property (p_mode0_upper) else $error("mode 0 touched upper bits");

  property p_ack_clears;
    @(posedge mclk) disable iff (!rst_n)
      (ack_timer1 && !t1_flag_src && !wr_ctrl) |=> !timer1_overflow_flag;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear flag");

  property p_edge_flag;
    @(posedge mclk) disable iff (!rst_n) (ext_irq1_type && x1_fall) |=> ext_irq1_flag;
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge missed");

  property p_ovf_pulse;
    @(posedge mclk) disable iff (!rst_n) t1_ovf |=> timer1_ovf_pulse;
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse missing");

  property p_borrow_flag;
    @(posedge mclk) disable iff (!rst_n) (timer0_in_mode3 && timer0_high_ovf) |=> timer1_overflow_flag;
  endproperty
  a_borrow_flag: assert property (p_borrow_flag) else $error("borrowed overflow did not set flag");

  property p_borrow_no_set;
    @(posedge mclk) disable iff (!rst_n)
      (timer0_in_mode3 && !timer0_high_ovf && !timer1_overflow_flag && !wr_ctrl) |=> !timer1_overflow_flag;
  endproperty
  a_borrow_no_set: assert property (p_borrow_no_set) else $error("timer 1 set a lent flag");

  property p_run_write;
    @(posedge mclk) disable iff (!rst_n) wr_ctrl
      |=> {timer1_run_bit, timer0_run_bit} == {$past(reg_wdata[`TCF_BIT_T1_RUN]), $past(reg_wdata[`TCF_BIT_T0_RUN])};
  endproperty
  a_run_write: assert property (p_run_write) else $error("run bits not written");

  property p_type_write;
    @(posedge mclk) disable iff (!rst_n) wr_ctrl
      |=> {ext_irq1_type, ext_irq0_type} == {$past(reg_wdata[`TCF_BIT_X1_TYPE]), $past(reg_wdata[`TCF_BIT_X0_TYPE])};
  endproperty
  a_type_write: assert property (p_type_write) else $error("type bits not written");

  property p_level_follow;
    @(posedge mclk) disable iff (!rst_n) !ext_irq1_type |=> ext_irq1_flag == !$past(ext_irq1_pin);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level flag does not follow pin");

  property p_mode0_carry;
    @(posedge mclk) disable iff (!rst_n)
      (inc && mode == TCF_MODE_13BIT && pre_wrap && !wr_high)
      |=> timer1_high_count == 8'($past(timer1_high_count) + 8'h1);
  endproperty
  a_mode0_carry: assert property (p_mode0_carry) else $error("prescaler wrap did not bump high byte");

  property p_mode1_carry;
    @(posedge mclk) disable iff (!rst_n)
      (inc && mode == TCF_MODE_16BIT && low_wrap && !wr_high)
      |=> timer1_high_count == 8'($past(timer1_high_count) + 8'h1);
  endproperty
  a_mode1_carry: assert property (p_mode1_carry) else $error("low wrap did not carry");

  c_reload: cover property (@(posedge mclk) disable iff (!rst_n) t1_ovf && mode == TCF_MODE_RELOAD);
  c_mode0: cover property (@(posedge mclk) disable iff (!rst_n) t1_ovf && mode == TCF_MODE_13BIT);
  c_mode1: cover property (@(posedge mclk) disable iff (!rst_n) t1_ovf && mode == TCF_MODE_16BIT);
  c_borrow: cover property (@(posedge mclk) disable iff (!rst_n) timer0_in_mode3 && timer0_high_ovf);
  c_counter: cover property (@(posedge mclk) disable iff (!rst_n) inc && timer1_source_select);

endmodule : tcf_timer1
`default_nettype wire

// ===== test/tcf_partner.sv
// far side model: count pin source and interrupt controller acknowledge
`timescale 1ns/10ps
`default_nettype none
module tcf_partner (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bench controls
  input wire logic ack_en,
  input wire logic pin_run,
  // flags seen from the block
  input wire logic [3:0] flags,
  // driven pins
  output logic count_pin,
  output logic [3:0] acks,
  output int falls
);
  int cnt;
  // each level held 30 cycles, well above one peripheral cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      count_pin <= 1'b1;
      falls <= 0;
    end else if (pin_run) begin
      cnt <= (cnt == 29) ? 0 : cnt + 1;
      if (cnt == 29) begin
        count_pin <= !count_pin;
        falls <= falls + (count_pin ? 1 : 0);
      end
    end
  end
  // vectoring acknowledge, one pulse per pending flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) acks <= 4'h0;
    else acks <= {4{ack_en}} & flags & ~acks;
  end
endmodule : tcf_partner
`default_nettype wire

// ===== test/test_timer1_with_control_flags.sv
// self-checking bench for the timer 1 block
`timescale 1ns/10ps
`default_nettype none
`include "tcf_defines.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module test_timer1_with_control_flags;
  import tcf_pkg::*;
  logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq1 = 1, irq0 = 1, t0m3 = 0, t0hov = 0, t0ov = 0;
  logic ack_en = 0, pin_run = 0, cpin, f7, f6, f5, f4, f3, f2, f1, f0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  tcf_byte_t h, l, d;
  logic [3:0] acks;
  logic ovp;
  logic [16:0] e;
  int bad_count = 0, checks = 0, seed = 54, falls, n, i, j, t, ovp_n = 0;
  always #2 mclk = ~mclk;
  tcf_timer1 dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .timer1_count_pin(cpin), .ext_irq1_pin(irq1), .ext_irq0_pin(irq0),
    .timer0_in_mode3(t0m3), .timer0_high_ovf(t0hov), .timer0_ovf(t0ov), .ack_timer1(acks[3]),
    .ack_timer0(acks[2]), .ack_ext1(acks[1]), .ack_ext0(acks[0]), .timer1_overflow_flag(f7),
    .timer1_run_bit(f6), .timer0_overflow_flag(f5), .timer0_run_bit(f4), .ext_irq1_flag(f3),
    .ext_irq1_type(f2), .ext_irq0_flag(f1), .ext_irq0_type(f0), .timer1_ovf_pulse(ovp));
  tcf_partner far (.mclk(mclk), .rst_n(rst_n), .ack_en(ack_en), .pin_run(pin_run), .flags({f7, f5, f3, f1}),
    .count_pin(cpin), .acks(acks), .falls(falls));
  // overflow pulses counted on the edge, before the design updates them
  always @(posedge mclk) begin
    if (ovp === 1'b1) ovp_n <= ovp_n + 1;
  end
  // expected count after k ticks, carry on top
  function automatic logic [16:0] nxt(bit m13, tcf_byte_t h, tcf_byte_t l, int k);
    logic [13:0] s;
    s = {1'b0, h, l[4:0]} + k[13:0];
    if (m13) return {s[13], s[12:5], 3'b000, s[4:0]};
    return {1'b0, h, l} + k[16:0];
  endfunction : nxt
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output tcf_byte_t v);
    @(posedge mclk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask : rd
  // exactly k ticks pass between the two mode writes; halting stops it
  task automatic run(input int k, input logic [7:0] m);
    wr(`TCF_ADDR_MODE, m);
    repeat (12 * k - 2) @(posedge mclk);
    wr(`TCF_ADDR_MODE, m | 8'h30);
  endtask : run
  task automatic wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values, then an unmapped address
    rd(`TCF_ADDR_CTRL, d); `CHK(d, 8'h00)
    rd(`TCF_ADDR_HIGH, d); `CHK(d, 8'h00)
    wr(8'h8A, 8'h5A);
    rd(8'h8A, d); `CHK(d, 8'h00)
    wr(`TCF_ADDR_CTRL, 8'h50);
    rd(`TCF_ADDR_CTRL, d); `CHK(d, 8'h50)
    `CHK({f7, f6, f5, f4, f3, f2, f1, f0}, 8'h50)
    // random preloads in 16-bit and 13-bit modes, last one wraps
    for (i = 0; i < 6; i++) begin
      h = $random(seed);
      l = $random(seed);
      if (i == 5) {h, l} = 16'hFFFF;
      wr(`TCF_ADDR_MODE, 8'h30);
      wr(`TCF_ADDR_CTRL, 8'h40);
      wr(`TCF_ADDR_LOW, l);
      wr(`TCF_ADDR_HIGH, h);
      n = ovp_n;
      run(i + 1, i[0] ? 8'h10 : 8'h00);
      e = nxt(!i[0], h, l, i + 1);
      cyc(30);
      rd(`TCF_ADDR_HIGH, d); `CHK(d, e[15:8])
      rd(`TCF_ADDR_LOW, d); `CHK(d & (i[0] ? 8'hFF : 8'h1F), e[7:0])
      `CHK(f7, e[16])
      `CHK(ovp_n - n, int'(e[16]))
    end
    // auto-reload with a random reload value, as a baud source would use
    h = $random(seed);
    wr(`TCF_ADDR_CTRL, 8'h40);
    wr(`TCF_ADDR_LOW, 8'hFF);
    wr(`TCF_ADDR_HIGH, h);
    wr(`TCF_ADDR_MODE, 8'h20);
    for (j = 0; j < 40 && f7 !== 1'b1; j++) @(posedge mclk);
    rd(`TCF_ADDR_LOW, d); `CHK(d, h)
    rd(`TCF_ADDR_HIGH, d); `CHK(d, h)
    `CHK(f7, 1'b1)
    ack_en <= 1'b1;
    cyc(5); `CHK(f7, 1'b0)
    ack_en <= 1'b0;
    // gate pin low blocks, high lets two ticks through, run off blocks
    wr(`TCF_ADDR_MODE, 8'h30);
    wr(`TCF_ADDR_LOW, 8'h00);
    for (t = 0; t < 3; t++) begin
      irq1 <= t[0];
      if (t == 2) wr(`TCF_ADDR_CTRL, 8'h00);
      run(2, t == 2 ? 8'h10 : 8'h90);
      rd(`TCF_ADDR_LOW, d); `CHK(d, 8'h02 * (t > 0))
    end
    // counter mode follows falling edges of the pin
    wr(`TCF_ADDR_CTRL, 8'h40);
    wr(`TCF_ADDR_LOW, 8'h00);
    pin_run <= 1'b1;
    n = falls;
    run(20, 8'h50);
    n = falls - n;
    rd(`TCF_ADDR_LOW, d); `CHK(int'(d) >= n - 1 && int'(d) <= n + 1 && n > 0, 1'b1)
    // both trigger types on both external pins
    for (t = 0; t < 2; t++) begin
      wr(`TCF_ADDR_CTRL, t ? 8'h05 : 8'h00);
      irq1 <= 1'b0;
      irq0 <= 1'b0;
      cyc(4); `CHK({f3, f1}, 2'b11)
      irq1 <= 1'b1;
      irq0 <= 1'b1;
      cyc(4); `CHK({f3, f1}, t ? 2'b11 : 2'b00)
      ack_en <= 1'b1;
      cyc(4); `CHK({f3, f1}, 2'b00)
      ack_en <= 1'b0;
      rd(`TCF_ADDR_CTRL, d); `CHK(d, t ? 8'h05 : 8'h00)
      `CHK({f2, f0}, t ? 2'b11 : 2'b00)
    end
    // timer 0 in mode 3 borrows the timer 1 flag
    t0m3 <= 1'b1;
    @(posedge mclk);
    t0hov <= 1'b1;
    @(posedge mclk);
    t0hov <= 1'b0;
    t0ov <= 1'b1;
    @(posedge mclk);
    t0ov <= 1'b0;
    cyc(2); `CHK({f7, f5}, 2'b11)
    // run bit lent to timer 0: timer 1 runs without it and never sets its flag
    wr(`TCF_ADDR_CTRL, 8'h00);
    wr(`TCF_ADDR_HIGH, 8'hFF);
    wr(`TCF_ADDR_LOW, 8'hFE);
    n = ovp_n;
    run(2, 8'h10);
    rd(`TCF_ADDR_LOW, d); `CHK(d, 8'h00)
    rd(`TCF_ADDR_HIGH, d); `CHK(d, 8'h00)
    `CHK(f7, 1'b0)
    `CHK(ovp_n - n, 1)
    // reset in mid-run brings every control bit back to zero
    t0m3 <= 1'b0;
    wr(`TCF_ADDR_CTRL, 8'h55);
    rd(`TCF_ADDR_CTRL, d); `CHK(d, 8'h55)
    @(posedge mclk);
    rst_n <= 1'b0;
    cyc(2);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd(`TCF_ADDR_CTRL, d); `CHK(d, 8'h00)
    `CHK({f7, f6, f5, f4, f3, f2, f1, f0}, 8'h00)
    wrap_up;
  end
endmodule : test_timer1_with_control_flags
`default_nettype wire
